/* File: logic/dfpc_pkg.sv */
package dfpc_pkg;

    // Register map: byte offsets on the device's internal register port.
    localparam logic [7:0] DFPC_DAC_FAULT_CONFIG_OFS   = 8'h43;
    localparam logic [7:0] DFPC_ADC_OVLD_MUTE_CFG_OFS  = 8'h4B;

    // Reset values of the two registers.
    localparam logic [7:0] DFPC_DAC_FAULT_CONFIG_RST   = 8'h50;
    localparam logic [7:0] DFPC_ADC_OVLD_MUTE_CFG_RST  = 8'h00;

    // Field positions in the fault configuration register.
    localparam int DFPC_POLICY_HI        = 6;
    localparam int DFPC_POLICY_LO        = 5;
    localparam int DFPC_RECOVERY_BIT     = 4;
    localparam int DFPC_SHUTDOWN_FLAG    = 3;
    localparam int DFPC_SKIP_GUARD_BIT   = 2;
    localparam int DFPC_DETECT_OFF_BIT   = 1;
    localparam int DFPC_REG_SHORT_BIT    = 0;

    // Field positions in the overload mute register.
    localparam int DFPC_IN1_MUTE_BIT     = 4;
    localparam int DFPC_IN2_MUTE_BIT     = 3;

    // Writable bits of each register; every other bit is reserved, except read-only bit 3 of the fault register.
    localparam logic [7:0] DFPC_DAC_FAULT_WMASK   = 8'h77;
    localparam logic [7:0] DFPC_ADC_OVLD_WMASK    = 8'h18;

    // Encodings of the shutdown policy field.
    localparam logic [1:0] DFPC_POLICY_IGNORE    = 2'h0;
    localparam logic [1:0] DFPC_POLICY_UNMASKED  = 2'h1;
    localparam logic [1:0] DFPC_POLICY_ANY       = 2'h2;

    // Number of DAC output channels and their synchroniser width, two detector bits per channel.
    localparam int DFPC_NCH       = 2;
    localparam int DFPC_SYNC_W    = 2 * DFPC_NCH;

    // Raw fault levels from the analog detectors of one output channel.
    typedef struct packed {
        logic driver_voltage_guard;
        logic short_circuit;
    } dfpc_fault_s;

    // One access on the internal register port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dfpc_reg_req_s;

endpackage : dfpc_pkg

/* File: logic/dfpc_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; a new level is accepted only when stages two and three agree.
module dfpc_sync
    import dfpc_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    // Each bit is filtered on its own so one noisy bit cannot hold back the others.
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1_reg[i]  <= 1'h0;
                    s2_reg[i]  <= 1'h0;
                    s3_reg[i]  <= 1'h0;
                    out_reg[i] <= 1'h0;
                end
                else
                begin
                    s1_reg[i] <= async_in[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i])
                    begin
                        out_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign sync_out = out_reg;

endmodule : dfpc_sync

/* File: logic/dfpc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - The two-bit policy field at bits 6-5 resets to 2 and picks ignore, unmasked-only or any fault, 3 reserved.
// - The recovery bit at bit 4 resets to 1; 0 re-powers channels once the fault clears, 1 keeps them down until their power request rises again.
// - Read-only bit 3 reads 1 while any output channel is held down by a fault and 0 otherwise.
// - With bit 2 set a driver voltage-guard fault during channel power-up does not shut the channel down.
// - Bit 1 set disables output voltage-guard and short detection so they neither flag nor shut down.
// - Bit 0 set disables short-circuit detection on the analog regulator.
// - With bit 4 of the mute register set, input channel 1 is muted while it is in overload recovery.
// - With bit 3 of the mute register set, input channel 2 is muted while it is in overload recovery.
// - Reserved bits read as zero, software writes only reset values there, and the device ignores them.
module dfpc_ctrl
    import dfpc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire dfpc_reg_req_s                 reg_req,
    output logic          [7:0]                reg_rdata,
    input  wire dfpc_fault_s [DFPC_NCH-1:0]    out_fault,
    input  wire logic     [DFPC_NCH-1:0]       out_fault_masked,
    input  wire logic     [DFPC_NCH-1:0]       out_powering_up,
    input  wire logic     [DFPC_NCH-1:0]       out_power_req,
    output logic          [DFPC_NCH-1:0]       out_power_en,
    output logic                               out_fault_detect_off,
    output logic                               regulator_short_detect_off,
    input  wire logic                          in1_overload_recovery,
    input  wire logic                          in2_overload_recovery,
    output logic                               in1_mute,
    output logic                               in2_mute
);

    logic [7:0]              dac_fault_config_reg;
    logic [7:0]              adc_overload_mute_config_reg;
    logic [7:0]              rdata_reg;
    logic [DFPC_NCH-1:0]     down_reg;
    logic [DFPC_NCH-1:0]     down_next;
    logic [DFPC_NCH-1:0]     req_d_reg;
    logic [DFPC_NCH-1:0]     power_en_reg;
    logic                    in1_mute_reg;
    logic                    in2_mute_reg;
    logic [DFPC_SYNC_W-1:0]  fault_sync;
    logic [DFPC_NCH-1:0]     guard_fault;
    logic [DFPC_NCH-1:0]     short_fault;
    logic [DFPC_NCH-1:0]     trig;
    logic [DFPC_NCH-1:0]     req_rise;

    // Analog detector levels arrive with no relation to clk, so they are filtered first.
    dfpc_sync #(
        .W        (DFPC_SYNC_W)
    ) u_fault_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (out_fault),
        .sync_out (fault_sync)
    );

    // Field decode of the configuration registers.
    wire [1:0] out_fault_shutdown_policy      = dac_fault_config_reg[DFPC_POLICY_HI:DFPC_POLICY_LO];
    wire       out_fault_recovery_manual      = dac_fault_config_reg[DFPC_RECOVERY_BIT];
    wire       skip_guard_shutdown_at_powerup = dac_fault_config_reg[DFPC_SKIP_GUARD_BIT];
    wire       out_fault_detect_off_cfg       = dac_fault_config_reg[DFPC_DETECT_OFF_BIT];
    wire       regulator_short_detect_off_cfg = dac_fault_config_reg[DFPC_REG_SHORT_BIT];
    wire       in1_overload_mute_en           = adc_overload_mute_config_reg[DFPC_IN1_MUTE_BIT];
    wire       in2_overload_mute_en           = adc_overload_mute_config_reg[DFPC_IN2_MUTE_BIT];
    wire       out_fault_shutdown_flag        = |down_reg;

    // Register port decode; writes outside the two offsets are dropped.
    wire wr_fault_cfg = reg_req.wr && (reg_req.addr == DFPC_DAC_FAULT_CONFIG_OFS);
    wire wr_mute_cfg  = reg_req.wr && (reg_req.addr == DFPC_ADC_OVLD_MUTE_CFG_OFS);
    wire rd_fault_cfg = reg_req.addr == DFPC_DAC_FAULT_CONFIG_OFS;
    wire rd_mute_cfg  = reg_req.addr == DFPC_ADC_OVLD_MUTE_CFG_OFS;

    // Read image: reserved bits are forced to zero and the status flag is spliced in.
    wire [7:0] fault_cfg_image = (dac_fault_config_reg & DFPC_DAC_FAULT_WMASK)
                               | ({7'h00, out_fault_shutdown_flag} << DFPC_SHUTDOWN_FLAG);
    wire [7:0] rd_mux = rd_fault_cfg ? fault_cfg_image
                      : rd_mute_cfg  ? (adc_overload_mute_config_reg & DFPC_ADC_OVLD_WMASK)
                      : 8'h00;

    // Configuration storage; reserved and read-only bits are masked off so they can never change.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dac_fault_config_reg         <= DFPC_DAC_FAULT_CONFIG_RST;
            adc_overload_mute_config_reg <= DFPC_ADC_OVLD_MUTE_CFG_RST;
        end
        else
        begin
            if (wr_fault_cfg)
            begin
                dac_fault_config_reg <= reg_req.wdata & DFPC_DAC_FAULT_WMASK;
            end
            if (wr_mute_cfg)
            begin
                adc_overload_mute_config_reg <= reg_req.wdata & DFPC_ADC_OVLD_WMASK;
            end
        end
    end

    // Read data is captured on the read strobe and held until the next one.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_reg <= 8'h00;
        end
        else if (reg_req.rd)
        begin
            rdata_reg <= rd_mux;
        end
    end

    // Per-channel fault qualification and shutdown tracking.
    genvar ch;
    generate
        for (ch = 0; ch < DFPC_NCH; ch++)
        begin : g_ch
            assign guard_fault[ch] = fault_sync[2*ch+1];
            assign short_fault[ch] = fault_sync[2*ch];
            // A guard trip during ramp-up is a known transient, so it may be waived.
            wire guard_counts = guard_fault[ch]
                                && !(skip_guard_shutdown_at_powerup && out_powering_up[ch]);
            wire detected     = !out_fault_detect_off_cfg && (guard_counts || short_fault[ch]);
            wire policy_hit   = (out_fault_shutdown_policy == DFPC_POLICY_ANY)
                             || ((out_fault_shutdown_policy == DFPC_POLICY_UNMASKED)
                                 && !out_fault_masked[ch]);
            assign trig[ch]     = detected && policy_hit;
            assign req_rise[ch] = out_power_req[ch] && !req_d_reg[ch];
            // A new trip wins over any release in the same cycle.
            assign down_next[ch] = trig[ch] ? 1'h1
                                 : !out_fault_recovery_manual ? 1'h0
                                 : (down_reg[ch] && !req_rise[ch]);
        end
    endgenerate

    // Shutdown state, request edge history and gated channel enables.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            down_reg     <= '0;
            req_d_reg    <= '0;
            power_en_reg <= '0;
        end
        else
        begin
            down_reg     <= down_next;
            req_d_reg    <= out_power_req;
            power_en_reg <= out_power_req & ~down_next;
        end
    end

    // Input mutes follow the recovery phase one cycle late; the detector shares clk.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            in1_mute_reg <= 1'h0;
            in2_mute_reg <= 1'h0;
        end
        else
        begin
            in1_mute_reg <= in1_overload_mute_en && in1_overload_recovery;
            in2_mute_reg <= in2_overload_mute_en && in2_overload_recovery;
        end
    end

    assign reg_rdata                  = rdata_reg;
    assign out_power_en               = power_en_reg;
    assign out_fault_detect_off       = dac_fault_config_reg[DFPC_DETECT_OFF_BIT];
    assign regulator_short_detect_off = dac_fault_config_reg[DFPC_REG_SHORT_BIT];
    assign in1_mute                   = in1_mute_reg;
    assign in2_mute                   = in2_mute_reg;

    // Checks on channel 0, the shutdown flag and mute register reads and the mute outputs; channel 1 is built by the same loop body.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_policy_ignore_hold: assert property (
        (out_fault_shutdown_policy == DFPC_POLICY_IGNORE && !down_reg[0]) |=> !down_reg[0])
        else $error("Channel went down while faults were ignored.");

    a_policy_any_down: assert property (
        (out_fault_shutdown_policy == DFPC_POLICY_ANY && !out_fault_detect_off_cfg && short_fault[0])
        |=> down_reg[0] && !out_power_en[0])
        else $error("Short fault under any-fault policy did not shut the channel down.");

    a_masked_fault_ignored: assert property (
        (out_fault_shutdown_policy == DFPC_POLICY_UNMASKED && out_fault_masked[0] && !down_reg[0])
        |=> !down_reg[0])
        else $error("Masked fault shut the channel down under unmasked policy.");

    a_auto_recovery_up: assert property (
        (!out_fault_recovery_manual && down_reg[0] && !trig[0]) |=> !down_reg[0])
        else $error("Auto recovery did not release the channel.");

    a_manual_hold_down: assert property (
        (out_fault_recovery_manual && down_reg[0] && !req_rise[0]) |=> down_reg[0])
        else $error("Manual recovery released a channel without a new request.");

    a_flag_read_status: assert property (
        (reg_req.rd && rd_fault_cfg) |=> rdata_reg[DFPC_SHUTDOWN_FLAG] == $past(|down_reg))
        else $error("Shutdown flag read back wrong.");

    a_reserved_read_zero: assert property (
        (reg_req.rd && rd_mute_cfg) |=> (rdata_reg & ~DFPC_ADC_OVLD_WMASK) == 8'h00)
        else $error("Reserved bits read as nonzero.");

    a_guard_skip_powerup: assert property (
        (skip_guard_shutdown_at_powerup && out_powering_up[0] && !short_fault[0] && !down_reg[0])
        |=> !down_reg[0])
        else $error("Guard fault during power-up shut the channel down.");

    a_detect_off_hold: assert property (
        (out_fault_detect_off_cfg && !down_reg[0]) |=> !down_reg[0])
        else $error("Channel went down with detection disabled.");

    a_in1_mute_follow: assert property (
        (in1_overload_mute_en && in1_overload_recovery) |=> in1_mute)
        else $error("Input 1 not muted during overload recovery.");

    a_in2_mute_off: assert property (
        !in2_overload_mute_en |=> !in2_mute)
        else $error("Input 2 muted while its mute option is off.");

    // Shared outputs, register writes, more checks on channel 0 and two checks on channel 1.
    a_in2_mute_follow: assert property (
        (in2_overload_mute_en && in2_overload_recovery) |=> in2_mute)
        else $error("Input 2 not muted during overload recovery.");

    a_in1_mute_off: assert property (
        !in1_overload_mute_en |=> !in1_mute)
        else $error("Input 1 muted while its mute option is off.");

    a_in1_idle_unmuted: assert property (
        !in1_overload_recovery |=> !in1_mute)
        else $error("Input 1 muted outside overload recovery.");

    a_in2_idle_unmuted: assert property (
        !in2_overload_recovery |=> !in2_mute)
        else $error("Input 2 muted outside overload recovery.");

    a_detect_off_write: assert property (
        wr_fault_cfg |=> out_fault_detect_off == $past(reg_req.wdata[DFPC_DETECT_OFF_BIT]))
        else $error("Output fault detection switch did not follow the write.");

    a_regulator_off_write: assert property (
        wr_fault_cfg |=> regulator_short_detect_off == $past(reg_req.wdata[DFPC_REG_SHORT_BIT]))
        else $error("Regulator short detection switch did not follow the write.");

    a_mute_write_lands: assert property (
        wr_mute_cfg |=> adc_overload_mute_config_reg == ($past(reg_req.wdata) & DFPC_ADC_OVLD_WMASK))
        else $error("Mute register write did not land with reserved bits cleared.");

    a_policy_reserved_hold: assert property (
        ((&out_fault_shutdown_policy) && !down_reg[0]) |=> !down_reg[0])
        else $error("Channel went down under the reserved policy code.");

    a_unmasked_down: assert property (
        (out_fault_shutdown_policy == DFPC_POLICY_UNMASKED && !out_fault_detect_off_cfg
         && short_fault[0] && !out_fault_masked[0]) |=> down_reg[0] && !out_power_en[0])
        else $error("Unmasked short fault did not shut the channel down.");

    a_guard_down_no_skip: assert property (
        (out_fault_shutdown_policy == DFPC_POLICY_ANY && !out_fault_detect_off_cfg
         && !skip_guard_shutdown_at_powerup && guard_fault[0]) |=> down_reg[0])
        else $error("Guard fault without the power-up waiver did not shut the channel down.");

    a_down_gates_power: assert property (
        !(|(down_reg & out_power_en)))
        else $error("A channel is powered while held down by a fault.");

    a_power_needs_req: assert property (
        !out_power_req[0] |=> !out_power_en[0])
        else $error("Channel powered without a power request.");

    a_manual_rearm_up: assert property (
        (out_fault_recovery_manual && down_reg[0] && !trig[0] && req_rise[0])
        |=> !down_reg[0] && out_power_en[0])
        else $error("Manual re-request with the fault gone did not power the channel up.");

    a_ch1_ignore_hold: assert property (
        (out_fault_shutdown_policy == DFPC_POLICY_IGNORE && !down_reg[1]) |=> !down_reg[1])
        else $error("Channel 1 went down while faults were ignored.");

    a_ch1_detect_off_hold: assert property (
        (out_fault_detect_off_cfg && !down_reg[1]) |=> !down_reg[1])
        else $error("Channel 1 went down with detection disabled.");

    c_fault_shutdown: cover property (trig[0] ##1 down_reg[0]);
    c_guard_waived: cover property (skip_guard_shutdown_at_powerup && out_powering_up[0] && guard_fault[0]);
    c_manual_rearm: cover property (out_fault_recovery_manual && down_reg[0] && !trig[0] && req_rise[0]);
    c_auto_release: cover property (!out_fault_recovery_manual && $fell(down_reg[0]));
    c_in1_muted: cover property (in1_mute);

endmodule : dfpc_ctrl

/* File: tb/dfpc_ctrl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module dfpc_ctrl_tb_top
    import dfpc_pkg::*;
;
    logic                        clk;
    logic                        rstn;
    dfpc_reg_req_s               req;
    logic        [7:0]           rdata;
    dfpc_fault_s [DFPC_NCH-1:0]  flt;
    logic        [DFPC_NCH-1:0]  masked;
    logic        [DFPC_NCH-1:0]  pwr_up;
    logic        [DFPC_NCH-1:0]  pwr_req;
    logic        [DFPC_NCH-1:0]  pwr_en;
    logic                        det_off;
    logic                        reg_off;
    logic                        rec1;
    logic                        rec2;
    logic                        mute1;
    logic                        mute2;
    int                          n_fail;
    int                          compares;
    int                          cfg43;
    int                          cfg4b;
    logic        [7:0]           tcfg [9];
    logic        [3:0]           tin  [9];

    dfpc_ctrl uut (.clk(clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata), .out_fault(flt),
        .out_fault_masked(masked), .out_powering_up(pwr_up), .out_power_req(pwr_req),
        .out_power_en(pwr_en), .out_fault_detect_off(det_off), .regulator_short_detect_off(reg_off),
        .in1_overload_recovery(rec1), .in2_overload_recovery(rec2), .in1_mute(mute1), .in2_mute(mute2));

    // Free-running 50 MHz clock.
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Prints the verdict and stops the run; used by the main sequence and the watchdog.
    task automatic finish_test();
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // One write strobe; the model keeps only the writable bits, as the device does.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        if (a == DFPC_DAC_FAULT_CONFIG_OFS) cfg43 = d & 8'h77;
        if (a == DFPC_ADC_OVLD_MUTE_CFG_OFS) cfg4b = d & 8'h18;
    endtask : wr_reg

    // One read strobe; data is looked at once the edge that takes the strobe has landed.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask : rd_reg

    // Reference decision: does this fault shut channel 0 down under this configuration.
    function automatic bit mdl_down(input logic [7:0] c, input logic [3:0] v);
        bit trig;
        trig = v[0] || (v[1] && !(v[2] && c[2]));
        if (c[1]) trig = 0;
        if (c[6:5] == 2'h0 || c[6:5] == 2'h3) trig = 0;
        if (c[6:5] == 2'h1 && v[3]) trig = 0;
        return trig;
    endfunction : mdl_down

    // One fault case on channel 0; channel 1 stays clean and must still be powered once the fault has settled.
    task automatic fault_case(input logic [7:0] c, input logic [3:0] v);
        logic [7:0] d;
        bit         dn;
        dn = mdl_down(c, v);
        wr_reg(DFPC_DAC_FAULT_CONFIG_OFS, c);
        #1 `CHK(det_off, c[1])
        `CHK(reg_off, c[0])
        masked[0] <= v[3];
        pwr_up[0] <= v[2];
        flt[0] <= '{driver_voltage_guard: v[1], short_circuit: v[0]};
        repeat (8) @(posedge clk);
        #1 `CHK(pwr_en, {1'h1, !dn})
        rd_reg(DFPC_DAC_FAULT_CONFIG_OFS, d);
        `CHK(d, 8'(cfg43 | (dn << 3)))
        flt[0] <= '0;
        repeat (8) @(posedge clk);
        #1 `CHK(pwr_en[0], !(dn && c[4]))
        if (dn && c[4])
        begin
            @(posedge clk);
            pwr_req[0] <= 1'h0;
            @(posedge clk);
            pwr_req[0] <= 1'h1;
            repeat (4) @(posedge clk);
            #1 `CHK(pwr_en[0], 1'h1)
        end
        rd_reg(DFPC_DAC_FAULT_CONFIG_OFS, d);
        `CHK(d, 8'(cfg43))
        masked[0] <= 1'h0;
        pwr_up[0] <= 1'h0;
    endtask : fault_case

    // Watchdog: the whole sequence needs well under 2000 cycles.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    // Main sequence.
    initial
    begin
        logic [7:0] d;
        logic [1:0] r;
        n_fail = 0;
        compares = 0;
        rstn = 1'h0;
        req = '0;
        flt = '0;
        masked = '0;
        pwr_up = '0;
        pwr_req = 2'h3;
        rec1 = 1'h0;
        rec2 = 1'h0;
        cfg43 = 8'h50;
        cfg4b = 8'h00;
        void'($urandom(32'hfd51b330));
        // Case table: {policy, manual, skip, detect off, 0} and {masked, powering up, guard, short}.
        tcfg = '{8'h40, 8'h00, 8'h60, 8'h20, 8'h20, 8'h42, 8'h44, 8'h40, 8'h50};
        tin  = '{4'h1, 4'h1, 4'h1, 4'h9, 4'h1, 4'h3, 4'h6, 4'h6, 4'h1};
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        rd_reg(DFPC_DAC_FAULT_CONFIG_OFS, d);
        `CHK(d, 8'h50)
        rd_reg(DFPC_ADC_OVLD_MUTE_CFG_OFS, d);
        `CHK(d, 8'h00)
        wr_reg(8'h44, 8'hFF);
        rd_reg(8'h44, d);
        `CHK(d, 8'h00)
        wr_reg(DFPC_DAC_FAULT_CONFIG_OFS, 8'hFF);
        rd_reg(DFPC_DAC_FAULT_CONFIG_OFS, d);
        `CHK(d, 8'h77)
        repeat (6) @(posedge clk);
        #1 `CHK(pwr_en, 2'h3)
        for (int i = 0; i < 9; i++)
            fault_case(tcfg[i] | 8'($urandom_range(1, 0)), tin[i]);
        // Mute: random enables and recovery phases, mute follows one cycle later.
        for (int i = 0; i < 24; i++)
        begin
            if (i % 4 == 0)
            begin
                wr_reg(DFPC_ADC_OVLD_MUTE_CFG_OFS, 8'($urandom));
                rd_reg(DFPC_ADC_OVLD_MUTE_CFG_OFS, d);
                `CHK(d, 8'(cfg4b))
            end
            r = 2'($urandom);
            @(posedge clk);
            rec1 <= r[0];
            rec2 <= r[1];
            @(posedge clk);
            #1 `CHK(mute1, cfg4b[4] & r[0])
            `CHK(mute2, cfg4b[3] & r[1])
        end
        finish_test();
    end
endmodule : dfpc_ctrl_tb_top
